/* File: core_exec_pkg.sv */
// shared constants and types for the instruction subset execution block
package core_exec_pkg;
    // widths and depths
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int FADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    localparam int CSTK_DEPTH = 16;
    localparam int CSTK_CNT_W = 5;
    localparam int BUS_ADDR_W = 5;
    localparam int BUS_DATA_W = 32;

    // register word indices on the bus
    localparam logic [4:0] REG_INSTR = 5'h00;
    localparam logic [4:0] REG_ACC = 5'h01;
    localparam logic [4:0] REG_PRODH = 5'h02;
    localparam logic [4:0] REG_STATUS = 5'h03;
    localparam logic [4:0] REG_PC = 5'h04;
    localparam logic [4:0] REG_DSP = 5'h05;
    localparam logic [4:0] REG_CTRL = 5'h06;
    localparam logic [4:0] REG_SH_PC = 5'h07;
    localparam logic [4:0] REG_SH_ACC = 5'h08;
    localparam logic [4:0] REG_SH_STATUS = 5'h09;
    localparam logic [4:0] REG_SH_SPEED = 5'h0A;
    localparam logic [4:0] REG_INTVEC = 5'h0B;
    localparam logic [4:0] REG_TIMER0 = 5'h0C;
    localparam logic [4:0] REG_CALL_PUSH = 5'h0D;
    localparam logic [4:0] REG_MEM_ADDR = 5'h0E;
    localparam logic [4:0] REG_MEM_DATA = 5'h0F;
    localparam logic [4:0] REG_CYCLES = 5'h10;

    // field positions
    localparam int STAT_Z_BIT = 2;
    localparam int PAGE_LSB = 5;
    localparam int PAGE_W = 3;
    localparam int SPEED_W = 3;
    localparam int CTRL_SKIP_BIT = 0;
    localparam int CTRL_SPEED_LSB = 1;
    localparam int RETI_SPEED_BIT = 2;
    localparam int RETI_VEC_BIT = 1;
    localparam int RETI_TMR_BIT = 0;

    // values after reset
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] DSP_RST = 16'h01FF;
    localparam logic [2:0] SPEED_RST = 3'h0;
    localparam logic [31:0] CYCLES_RST = 32'h00000000;

    // architectural cycle costs
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_TRANSFER = 2'h3;

    // opcode patterns
    localparam logic [6:0] PFX_NOT_F = 7'h13;
    localparam logic [6:0] PFX_NOT_W = 7'h12;
    localparam logic [6:0] PFX_OR_FW = 7'h09;
    localparam logic [6:0] PFX_OR_WF = 7'h08;
    localparam logic [6:0] PFX_POP = 7'h23;
    localparam logic [6:0] PFX_PUSH_F = 7'h22;
    localparam logic [7:0] BYTE_MULU_LIT = 8'h72;
    localparam logic [7:0] BYTE_OR_LIT = 8'h7D;
    localparam logic [7:0] BYTE_PUSH_LIT = 8'h74;
    localparam logic [15:0] WORD_NOP = 16'h0000;
    localparam logic [15:0] WORD_RET = 16'h0007;
    localparam logic [12:0] TOP_RETI = 13'h0001;
    localparam logic [12:0] TOP_PAGE = 13'h0002;

    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_MULU_LIT = 4'b0001,
        OP_NOT_F = 4'b0010,
        OP_NOT_W = 4'b0011,
        OP_OR_FW = 4'b0100,
        OP_OR_WF = 4'b0101,
        OP_OR_LIT = 4'b0110,
        OP_PAGE = 4'b0111,
        OP_POP = 4'b1000,
        OP_PUSH_F = 4'b1001,
        OP_PUSH_LIT = 4'b1010,
        OP_RET = 4'b1011,
        OP_RETI = 4'b1100,
        OP_OTHER = 4'b1101
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_EXEC = 3'b001,
        ST_HOLD = 3'b010,
        ST_MEMRD = 3'b011,
        ST_ACK = 3'b100
    } state_t;

    typedef struct packed {
        logic en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_t;
endpackage

/* File: data_mem.sv */
// file register and data stack storage with registered read data
module data_mem (
    // clock
    input wire logic clk_i,
    // write port
    input wire core_exec_pkg::mem_wr_t wr_i,
    // read port
    input wire logic [core_exec_pkg::FADDR_W-1:0] rd_addr_i,
    output logic [core_exec_pkg::DATA_W-1:0] rd_data_o
);
    logic [core_exec_pkg::DATA_W-1:0] mem [0:core_exec_pkg::MEM_DEPTH-1];

    // read returns old data when the same word is written in that cycle
    always_ff @(posedge clk_i) begin
        if (wr_i.en) begin
            mem[wr_i.addr] <= wr_i.data;
        end
        rd_data_o <= mem[rd_addr_i];
    end
endmodule

/* File: cpu_instr_subset_exec.sv */
// execution of a subset of the core instruction set behind an Avalon-MM slave
// Function
// - unsigned multiply by literal: low byte to accumulator, high to product high byte
// - all-zero word changes nothing and costs one cycle
// - complement file register in place, zero flag from result
// - complement file register into accumulator, register kept, zero flag from result
// - OR accumulator into file register, accumulator kept, zero flag from result
// - OR file register into accumulator, register kept, zero flag from result
// - OR literal into accumulator, zero flag from result
// - page instruction loads three-bit operand into status bits 7:5
// - true skip before page instructions skips them all plus next, one cycle each
// - pop increments data stack pointer, then loads that byte into file register
// - push register writes at data stack pointer, then decrements it
// - push literal writes at data stack pointer, then decrements it
// - return pops 16-bit address into program counter, page bits follow, three cycles
// - call stack storage is separate from the data stack
// - interrupt return restores counter, accumulator and whole status from shadows
// - return options: bit2 speed, bit1 vector gets return plus one, bit0 timer adds acc
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
module cpu_instr_subset_exec (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // avalon-mm slave
    input wire logic [core_exec_pkg::BUS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [core_exec_pkg::BUS_DATA_W-1:0] avs_writedata_i,
    output logic [core_exec_pkg::BUS_DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // core state
    output logic [core_exec_pkg::PC_W-1:0] pc_o,
    output logic [core_exec_pkg::SPEED_W-1:0] speed_o
);
    // instruction classification, used for issue and execute
    function automatic core_exec_pkg::op_t decode(input logic [15:0] iw);
        core_exec_pkg::op_t op;
        op = core_exec_pkg::OP_OTHER;
        if (iw == core_exec_pkg::WORD_NOP) op = core_exec_pkg::OP_NOP;
        else if (iw == core_exec_pkg::WORD_RET) op = core_exec_pkg::OP_RET;
        else if (iw[15:3] == core_exec_pkg::TOP_RETI) op = core_exec_pkg::OP_RETI;
        else if (iw[15:3] == core_exec_pkg::TOP_PAGE) op = core_exec_pkg::OP_PAGE;
        else if (iw[15:8] == core_exec_pkg::BYTE_MULU_LIT) op = core_exec_pkg::OP_MULU_LIT;
        else if (iw[15:8] == core_exec_pkg::BYTE_OR_LIT) op = core_exec_pkg::OP_OR_LIT;
        else if (iw[15:8] == core_exec_pkg::BYTE_PUSH_LIT) op = core_exec_pkg::OP_PUSH_LIT;
        else if (iw[15:9] == core_exec_pkg::PFX_NOT_F) op = core_exec_pkg::OP_NOT_F;
        else if (iw[15:9] == core_exec_pkg::PFX_NOT_W) op = core_exec_pkg::OP_NOT_W;
        else if (iw[15:9] == core_exec_pkg::PFX_OR_FW) op = core_exec_pkg::OP_OR_FW;
        else if (iw[15:9] == core_exec_pkg::PFX_OR_WF) op = core_exec_pkg::OP_OR_WF;
        else if (iw[15:9] == core_exec_pkg::PFX_POP) op = core_exec_pkg::OP_POP;
        else if (iw[15:9] == core_exec_pkg::PFX_PUSH_F) op = core_exec_pkg::OP_PUSH_F;
        return op;
    endfunction

    // zero test shared by every instruction that sets the zero flag from a result
    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // registers
    core_exec_pkg::state_t state_ff, nxt_state;
    logic [15:0] instr_ff;
    logic [7:0] acc_ff, nxt_acc;
    logic [7:0] prodh_ff, nxt_prodh;
    logic [7:0] status_ff, nxt_status;
    logic [15:0] pc_ff, nxt_pc;
    logic [15:0] dsp_ff, nxt_dsp;
    logic skip_ff, nxt_skip;
    logic [2:0] speed_ff, nxt_speed;
    logic [15:0] sh_pc_ff, nxt_sh_pc;
    logic [7:0] sh_acc_ff, nxt_sh_acc;
    logic [7:0] sh_status_ff, nxt_sh_status;
    logic [2:0] sh_speed_ff, nxt_sh_speed;
    logic [15:0] intvec_ff, nxt_intvec;
    logic [7:0] timer0_ff, nxt_timer0;
    logic [4:0] cstk_cnt_ff, nxt_cstk_cnt;
    logic [15:0] cstk_ff [0:core_exec_pkg::CSTK_DEPTH-1];
    logic [8:0] mem_addr_ff, nxt_mem_addr;
    logic [31:0] cycles_ff, nxt_cycles;
    logic [1:0] hold_ff, nxt_hold;
    logic waitreq_ff;
    logic [31:0] rdata_ff, nxt_rdata;

    // bus decode
    wire logic idle = (state_ff == core_exec_pkg::ST_IDLE);
    wire logic req = avs_read_i | avs_write_i;
    wire logic take = idle & req;
    wire logic instr_wr = avs_write_i & (avs_address_i == core_exec_pkg::REG_INSTR);
    wire logic mem_rd = avs_read_i & (avs_address_i == core_exec_pkg::REG_MEM_DATA);
    wire logic reg_wr = take & avs_write_i & ~instr_wr;
    wire logic [7:0] wr_byte = avs_writedata_i[7:0];
    wire logic [15:0] wr_word = avs_writedata_i[15:0];
    wire logic push_ok = reg_wr & (avs_address_i == core_exec_pkg::REG_CALL_PUSH)
                         & (cstk_cnt_ff != 5'(core_exec_pkg::CSTK_DEPTH));

    // execute operands
    wire core_exec_pkg::op_t op = decode(instr_ff);
    wire logic [8:0] fr_addr = instr_ff[8:0];
    wire logic [7:0] imm = instr_ff[7:0];
    wire logic [7:0] mem_q;
    wire logic [15:0] dsp_up = dsp_ff + 16'h0001;
    wire logic [15:0] dsp_down = dsp_ff - 16'h0001;
    wire logic [15:0] product = {8'h00, acc_ff} * {8'h00, imm};
    wire logic [7:0] not_res = ~mem_q;
    wire logic [7:0] or_reg = mem_q | acc_ff;
    wire logic [7:0] or_lit = acc_ff | imm;
    wire logic cstk_empty = (cstk_cnt_ff == 5'h00);
    wire logic [15:0] cstk_top = cstk_empty ? core_exec_pkg::WORD_RST
                                            : cstk_ff[4'(cstk_cnt_ff - 5'h01)];

    // pop reads one above the pointer; everything else reads its operand address
    wire logic [8:0] rd_addr = !instr_wr ? mem_addr_ff
                             : (decode(wr_word) == core_exec_pkg::OP_POP) ? dsp_up[8:0]
                             : wr_word[8:0];

    core_exec_pkg::mem_wr_t mem_wr;
    logic [1:0] cost;

    data_mem u_mem (
        .clk_i(clk_i),
        .wr_i(mem_wr),
        .rd_addr_i(rd_addr),
        .rd_data_o(mem_q)
    );

    // execute stage and software register writes; both never happen in one cycle
    always_comb begin
        nxt_acc = acc_ff;
        nxt_prodh = prodh_ff;
        nxt_status = status_ff;
        nxt_pc = pc_ff;
        nxt_dsp = dsp_ff;
        nxt_skip = skip_ff;
        nxt_speed = speed_ff;
        nxt_sh_pc = sh_pc_ff;
        nxt_sh_acc = sh_acc_ff;
        nxt_sh_status = sh_status_ff;
        nxt_sh_speed = sh_speed_ff;
        nxt_intvec = intvec_ff;
        nxt_timer0 = timer0_ff;
        nxt_cstk_cnt = cstk_cnt_ff + {4'h0, push_ok};
        nxt_mem_addr = mem_addr_ff;
        nxt_cycles = cycles_ff;
        mem_wr = '{en: 1'b0, addr: mem_addr_ff, data: wr_byte};
        cost = core_exec_pkg::CYC_SINGLE;
        if (state_ff == core_exec_pkg::ST_EXEC) begin
            if (skip_ff) begin
                nxt_skip = (op == core_exec_pkg::OP_PAGE);
            end else begin
                unique case (op)
                    core_exec_pkg::OP_NOP, core_exec_pkg::OP_OTHER: begin
                        nxt_skip = skip_ff;
                    end
                    core_exec_pkg::OP_MULU_LIT: begin
                        nxt_acc = product[7:0];
                        nxt_prodh = product[15:8];
                    end
                    core_exec_pkg::OP_NOT_F: begin
                        mem_wr = '{en: 1'b1, addr: fr_addr, data: not_res};
                        nxt_status[core_exec_pkg::STAT_Z_BIT] = is_zero(not_res);
                    end
                    core_exec_pkg::OP_NOT_W: begin
                        nxt_acc = not_res;
                        nxt_status[core_exec_pkg::STAT_Z_BIT] = is_zero(not_res);
                    end
                    core_exec_pkg::OP_OR_FW: begin
                        mem_wr = '{en: 1'b1, addr: fr_addr, data: or_reg};
                        nxt_status[core_exec_pkg::STAT_Z_BIT] = is_zero(or_reg);
                    end
                    core_exec_pkg::OP_OR_WF: begin
                        nxt_acc = or_reg;
                        nxt_status[core_exec_pkg::STAT_Z_BIT] = is_zero(or_reg);
                    end
                    core_exec_pkg::OP_OR_LIT: begin
                        nxt_acc = or_lit;
                        nxt_status[core_exec_pkg::STAT_Z_BIT] = is_zero(or_lit);
                    end
                    core_exec_pkg::OP_PAGE: begin
                        nxt_status[7:5] = instr_ff[2:0];
                    end
                    core_exec_pkg::OP_POP: begin
                        mem_wr = '{en: 1'b1, addr: fr_addr, data: mem_q};
                        nxt_dsp = dsp_up;
                    end
                    core_exec_pkg::OP_PUSH_F: begin
                        mem_wr = '{en: 1'b1, addr: dsp_ff[8:0], data: mem_q};
                        nxt_dsp = dsp_down;
                    end
                    core_exec_pkg::OP_PUSH_LIT: begin
                        mem_wr = '{en: 1'b1, addr: dsp_ff[8:0], data: imm};
                        nxt_dsp = dsp_down;
                    end
                    core_exec_pkg::OP_RET: begin
                        // call stack is its own array, data stack pointer untouched
                        nxt_pc = cstk_top;
                        nxt_status[7:5] = cstk_top[15:13];
                        nxt_cstk_cnt = cstk_empty ? cstk_cnt_ff : cstk_cnt_ff - 5'h01;
                        cost = core_exec_pkg::CYC_TRANSFER;
                    end
                    core_exec_pkg::OP_RETI: begin
                        nxt_pc = sh_pc_ff;
                        nxt_acc = sh_acc_ff;
                        nxt_status = sh_status_ff;
                        cost = core_exec_pkg::CYC_TRANSFER;
                        if (instr_ff[core_exec_pkg::RETI_SPEED_BIT]) begin
                            nxt_speed = sh_speed_ff;
                        end
                        if (instr_ff[core_exec_pkg::RETI_VEC_BIT]) begin
                            nxt_intvec = sh_pc_ff + 16'h0001;
                        end
                        if (instr_ff[core_exec_pkg::RETI_TMR_BIT]) begin
                            nxt_timer0 = timer0_ff + acc_ff;
                        end
                    end
                endcase
            end
            // skipped words still cost their one cycle
            nxt_cycles = cycles_ff + {30'h0, cost};
        end else if (reg_wr) begin
            unique case (avs_address_i)
                core_exec_pkg::REG_ACC: nxt_acc = wr_byte;
                core_exec_pkg::REG_PRODH: nxt_prodh = wr_byte;
                core_exec_pkg::REG_STATUS: nxt_status = wr_byte;
                core_exec_pkg::REG_PC: nxt_pc = wr_word;
                core_exec_pkg::REG_DSP: nxt_dsp = wr_word;
                core_exec_pkg::REG_CTRL: begin
                    nxt_skip = avs_writedata_i[core_exec_pkg::CTRL_SKIP_BIT];
                    nxt_speed = avs_writedata_i[core_exec_pkg::CTRL_SPEED_LSB +: 3];
                end
                core_exec_pkg::REG_SH_PC: nxt_sh_pc = wr_word;
                core_exec_pkg::REG_SH_ACC: nxt_sh_acc = wr_byte;
                core_exec_pkg::REG_SH_STATUS: nxt_sh_status = wr_byte;
                core_exec_pkg::REG_SH_SPEED: nxt_sh_speed = avs_writedata_i[2:0];
                core_exec_pkg::REG_INTVEC: nxt_intvec = wr_word;
                core_exec_pkg::REG_TIMER0: nxt_timer0 = wr_byte;
                core_exec_pkg::REG_MEM_ADDR: nxt_mem_addr = avs_writedata_i[8:0];
                core_exec_pkg::REG_MEM_DATA: mem_wr.en = 1'b1;
                default: nxt_mem_addr = mem_addr_ff; // unmapped, read-only or call push (done by push_ok): no change here
            endcase
        end
    end

    // sequencing: accept, execute, hold for multi-cycle words, answer
    always_comb begin
        nxt_state = state_ff;
        nxt_hold = hold_ff;
        unique case (state_ff)
            core_exec_pkg::ST_IDLE: begin
                if (req) begin
                    nxt_state = instr_wr ? core_exec_pkg::ST_EXEC
                              : mem_rd ? core_exec_pkg::ST_MEMRD : core_exec_pkg::ST_ACK;
                end
            end
            core_exec_pkg::ST_EXEC: begin
                nxt_hold = cost - 2'h1;
                nxt_state = (cost == core_exec_pkg::CYC_SINGLE) ? core_exec_pkg::ST_ACK
                                                                : core_exec_pkg::ST_HOLD;
            end
            core_exec_pkg::ST_HOLD: begin
                nxt_hold = hold_ff - 2'h1;
                if (hold_ff == 2'h1) begin
                    nxt_state = core_exec_pkg::ST_ACK;
                end
            end
            core_exec_pkg::ST_MEMRD: nxt_state = core_exec_pkg::ST_ACK;
            core_exec_pkg::ST_ACK: nxt_state = core_exec_pkg::ST_IDLE;
            default: nxt_state = core_exec_pkg::ST_IDLE;
        endcase
    end

    // read data, captured as the answer is given
    always_comb begin
        unique case (avs_address_i)
            core_exec_pkg::REG_INSTR: nxt_rdata = {16'h0000, instr_ff};
            core_exec_pkg::REG_ACC: nxt_rdata = {24'h000000, acc_ff};
            core_exec_pkg::REG_PRODH: nxt_rdata = {24'h000000, prodh_ff};
            core_exec_pkg::REG_STATUS: nxt_rdata = {24'h000000, status_ff};
            core_exec_pkg::REG_PC: nxt_rdata = {16'h0000, pc_ff};
            core_exec_pkg::REG_DSP: nxt_rdata = {16'h0000, dsp_ff};
            core_exec_pkg::REG_CTRL: nxt_rdata = {28'h0000000, speed_ff, skip_ff};
            core_exec_pkg::REG_SH_PC: nxt_rdata = {16'h0000, sh_pc_ff};
            core_exec_pkg::REG_SH_ACC: nxt_rdata = {24'h000000, sh_acc_ff};
            core_exec_pkg::REG_SH_STATUS: nxt_rdata = {24'h000000, sh_status_ff};
            core_exec_pkg::REG_SH_SPEED: nxt_rdata = {29'h00000000, sh_speed_ff};
            core_exec_pkg::REG_INTVEC: nxt_rdata = {16'h0000, intvec_ff};
            core_exec_pkg::REG_TIMER0: nxt_rdata = {24'h000000, timer0_ff};
            core_exec_pkg::REG_CALL_PUSH: nxt_rdata = {27'h0000000, cstk_cnt_ff};
            core_exec_pkg::REG_MEM_ADDR: nxt_rdata = {23'h000000, mem_addr_ff};
            core_exec_pkg::REG_MEM_DATA: nxt_rdata = {24'h000000, mem_q};
            core_exec_pkg::REG_CYCLES: nxt_rdata = cycles_ff;
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    // call stack entries carry no reset: only the count marks them valid
    always_ff @(posedge clk_i) begin
        if (push_ok) begin
            cstk_ff[cstk_cnt_ff[3:0]] <= wr_word;
        end
    end

    // control and architectural state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= core_exec_pkg::ST_IDLE;
            instr_ff <= core_exec_pkg::WORD_RST;
            acc_ff <= core_exec_pkg::BYTE_RST;
            prodh_ff <= core_exec_pkg::BYTE_RST;
            status_ff <= core_exec_pkg::BYTE_RST;
            pc_ff <= core_exec_pkg::WORD_RST;
            dsp_ff <= core_exec_pkg::DSP_RST;
            skip_ff <= 1'b0;
            speed_ff <= core_exec_pkg::SPEED_RST;
            sh_pc_ff <= core_exec_pkg::WORD_RST;
            sh_acc_ff <= core_exec_pkg::BYTE_RST;
            sh_status_ff <= core_exec_pkg::BYTE_RST;
            sh_speed_ff <= core_exec_pkg::SPEED_RST;
            intvec_ff <= core_exec_pkg::WORD_RST;
            timer0_ff <= core_exec_pkg::BYTE_RST;
            cstk_cnt_ff <= 5'h00;
            mem_addr_ff <= 9'h000;
            cycles_ff <= core_exec_pkg::CYCLES_RST;
            hold_ff <= 2'h0;
            waitreq_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            instr_ff <= (take & instr_wr) ? wr_word : instr_ff;
            acc_ff <= nxt_acc;
            prodh_ff <= nxt_prodh;
            status_ff <= nxt_status;
            pc_ff <= nxt_pc;
            dsp_ff <= nxt_dsp;
            skip_ff <= nxt_skip;
            speed_ff <= nxt_speed;
            sh_pc_ff <= nxt_sh_pc;
            sh_acc_ff <= nxt_sh_acc;
            sh_status_ff <= nxt_sh_status;
            sh_speed_ff <= nxt_sh_speed;
            intvec_ff <= nxt_intvec;
            timer0_ff <= nxt_timer0;
            cstk_cnt_ff <= nxt_cstk_cnt;
            mem_addr_ff <= nxt_mem_addr;
            cycles_ff <= nxt_cycles;
            hold_ff <= nxt_hold;
            // waitrequest drops for exactly the answer cycle
            waitreq_ff <= (nxt_state != core_exec_pkg::ST_ACK);
            rdata_ff <= (nxt_state == core_exec_pkg::ST_ACK) ? nxt_rdata : rdata_ff;
        end
    end

    // outputs straight from flops
    assign avs_readdata_o = rdata_ff;
    assign avs_waitrequest_o = waitreq_ff;
    assign pc_o = pc_ff;
    assign speed_o = speed_ff;
endmodule

/* File: cpu_instr_subset_exec_checker.sv */
// bus timing and core state checks for the instruction subset block
module cpu_instr_subset_exec_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus and core state
    input wire logic [core_exec_pkg::BUS_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [core_exec_pkg::BUS_DATA_W-1:0] avs_writedata_i,
    input wire logic [core_exec_pkg::BUS_DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [core_exec_pkg::PC_W-1:0] pc_o,
    input wire logic [core_exec_pkg::SPEED_W-1:0] speed_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic pend_ff;
    // a request first seen waiting marks the take edge
    wire req = avs_read_i | avs_write_i;
    wire start = req & avs_waitrequest_o & ~pend_ff;
    wire [15:0] w = avs_writedata_i[15:0];
    wire instr = start & avs_write_i & (avs_address_i == core_exec_pkg::REG_INSTR);
    wire memrd = start & avs_read_i & (avs_address_i == core_exec_pkg::REG_MEM_DATA);
    wire is_ret = instr & (w == core_exec_pkg::WORD_RET);
    wire is_reti = instr & (w[15:3] == core_exec_pkg::TOP_RETI);
    wire is_one = instr & ~is_ret & ~is_reti;
    // skip state is not visible here, so the cost checks assume no skipped word is a return
    always_ff @(posedge clk_i) begin
        pend_ff <= rst_i ? 1'b0 : (req & avs_waitrequest_o);
    end
    sequence ans_late;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    one_cycle_a: assert property (is_one |=> ans_late)
        else $error("single cycle word answered late");
    ret_cost_a: assert property (is_ret |=> avs_waitrequest_o [*2] ##1 ans_late)
        else $error("return did not take three cycles");
    reti_cost_a: assert property (is_reti |=> avs_waitrequest_o [*2] ##1 ans_late)
        else $error("interrupt return did not take three cycles");
    plain_answer_a: assert property (start & ~instr & ~memrd |=> !avs_waitrequest_o)
        else $error("register access not answered next cycle");
    answer_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer longer than one cycle");
    readdata_hold_a: assert property ($changed(avs_readdata_o) |-> !avs_waitrequest_o)
        else $error("read data moved outside an answer");
    pc_keep_a: assert property (is_one |=> $stable(pc_o) [*3])
        else $error("ordinary word changed the program counter");
    speed_keep_a: assert property (instr & ~(is_reti & w[2]) |=> $stable(speed_o) [*3])
        else $error("speed changed without a restore option");
endmodule

/* File: cpu_instr_subset_exec_test.sv */
// self-checking bench for the instruction subset block
module cpu_instr_subset_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o, q, base, rd;
    logic avs_waitrequest_o;
    logic [15:0] pc_o;
    logic [2:0] speed_o;
    int n_errors = 0;
    int num_checks = 0;
    // kind, register, value: 1 write, 2 read, 3 speed, 4 mark cycles, 5 cycles since mark, 0 end
    logic [27:0] tbl [] = '{28'h2010000, 28'h20501FF, 28'h2040000, 28'h21F0000, 28'h20D0000,
        28'h0000001, 28'h10100F3, 28'h100720A, 28'h201007E, 28'h2020009, 28'h4100000,
        28'h1000000, 28'h201007E, 28'h2020009, 28'h5100001, 28'h0000002,
        28'h1010000, 28'h10300E1, 28'h1007D00, 28'h2010000, 28'h20300E5, 28'h1007D50,
        28'h2010050, 28'h20300E1, 28'h10E0099, 28'h10F00FF, 28'h1002699, 28'h20F0000,
        28'h20300E5, 28'h1002499, 28'h20100FF, 28'h20300E1, 28'h20F0000, 28'h1001299,
        28'h20F00FF, 28'h20100FF, 28'h20300E1, 28'h10F0000, 28'h1010000, 28'h1001099,
        28'h2010000, 28'h20300E5, 28'h1000015, 28'h20300A5, 28'h0000003,
        28'h10F005A, 28'h1004499, 28'h20501FE, 28'h10074C3, 28'h20501FD, 28'h1004699,
        28'h20501FE, 28'h20F00C3, 28'h10E01FF, 28'h20F005A, 28'h20D0000, 28'h0000004,
        28'h10DC123, 28'h20D0001, 28'h1000007, 28'h204C123, 28'h20300C5, 28'h20D0000,
        28'h20501FE, 28'h0000005, 28'h1071234, 28'h1080033, 28'h1090021, 28'h10A0005,
        28'h10C0010, 28'h1060004, 28'h3000002, 28'h1010007, 28'h100000F, 28'h2041234,
        28'h2010033, 28'h2030021, 28'h3000005, 28'h20B1235, 28'h20C0017, 28'h10A0001,
        28'h1000008, 28'h3000005, 28'h20C0017, 28'h2041234, 28'h0000006, 28'h4100000,
        28'h106000B, 28'h1000012, 28'h1000013, 28'h1007DFF, 28'h2030021, 28'h2010033,
        28'h206000A, 28'h5100003, 28'h3000005, 28'h0000007};
    cpu_instr_subset_exec dut_u (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .pc_o(pc_o), .speed_o(speed_o));
    function automatic void chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endfunction
    // one bus cycle; request held until a rising edge samples waitrequest low
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= ~w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 40);
        r = avs_readdata_o;
        chk({31'h0, avs_waitrequest_o}, 32'h00000000);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // table walk: each row is one access, one check or a test-done marker
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (tbl[i]) begin
            q = {16'h0000, tbl[i][15:0]};
            case (tbl[i][27:24])
                4'h0: $display("test %0d done", q);
                4'h1: xfer(1'b1, tbl[i][20:16], q, rd);
                4'h3: chk({29'h0, speed_o}, q);
                4'h4: xfer(1'b0, tbl[i][20:16], 32'h00000000, base);
                default: begin
                    xfer(1'b0, tbl[i][20:16], 32'h00000000, rd);
                    chk(rd, (tbl[i][27:24] == 4'h5 ? base : 32'h0) + q);
                end
            endcase
        end
        give_verdict;
    end
    // hang guard, far beyond the few hundred cycles the table needs
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        give_verdict;
    end
endmodule
bind cpu_instr_subset_exec cpu_instr_subset_exec_checker chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pc_o(pc_o), .speed_o(speed_o));
